/* File: include/lrt_defs.svh */
// offsets, reset values, field positions and timing counts for the tracking parameter bank
`ifndef LRT_DEFS_SVH
`define LRT_DEFS_SVH

`define LRT_ADDR_CTRL 8'h48
`define LRT_ADDR_PER_HI 8'h6A
`define LRT_ADDR_PER_LO 8'h6B
`define LRT_ADDR_POS_LIM 8'h72
`define LRT_ADDR_NEG_LIM 8'h73
`define LRT_ADDR_BRAKE 8'h78
`define LRT_ADDR_PLAY_DUR 8'h79
`define LRT_ADDR_NZC 8'h7A
`define LRT_ADDR_NORM_AMP 8'h7B
`define LRT_ADDR_OVD_AMP 8'h7C
`define LRT_ADDR_FIRST 8'h7D
`define LRT_ADDR_REPEAT 8'h7E
`define LRT_ADDR_LATER 8'h7F

`define LRT_RST_CTRL 8'h99
`define LRT_RST_PER_HI 8'h00
`define LRT_RST_PER_LO 8'h00
`define LRT_RST_POS_LIM 8'h0F
`define LRT_RST_NEG_LIM 8'hF1
`define LRT_RST_BRAKE 8'h53
`define LRT_RST_PLAY_DUR 8'h3F
`define LRT_RST_NZC 8'h1F
`define LRT_RST_NORM_AMP 8'h50
`define LRT_RST_OVD_AMP 8'h7F
`define LRT_RST_FIRST 8'h59
`define LRT_RST_REPEAT 8'h05
`define LRT_RST_LATER 8'h0F

`define LRT_CTRL_CLOSED_BIT 3
`define LRT_CTRL_TIMED_BIT 4
`define LRT_BRAKE_MSB 3
`define LRT_BRAKE_LSB 0
`define LRT_FIRST_MSB 7
`define LRT_FIRST_LSB 4

`define LRT_CLK_PERIOD_PS 10000
`define LRT_PERIOD_LSB_PS 2600
`define LRT_PLAY_UNIT_PS 666670000
`define LRT_NZC_UNIT_PS 166670000
`define LRT_PLAY_UNIT_CYC (`LRT_PLAY_UNIT_PS / `LRT_CLK_PERIOD_PS)
`define LRT_NZC_UNIT_CYC (`LRT_NZC_UNIT_PS / `LRT_CLK_PERIOD_PS)

`endif

/* File: include/lrt_pkg.sv */
// types shared by the tracking parameter bank
package lrt_pkg;
  typedef logic [7:0] lrt_byte_t;
  typedef logic [15:0] lrt_period_t;
  typedef enum {
    LRT_R_CTRL, LRT_R_PER_HI, LRT_R_PER_LO, LRT_R_POS_LIM, LRT_R_NEG_LIM, LRT_R_BRAKE,
    LRT_R_PLAY_DUR, LRT_R_NZC, LRT_R_NORM_AMP, LRT_R_OVD_AMP, LRT_R_FIRST, LRT_R_REPEAT,
    LRT_R_LATER, LRT_R_COUNT
  } lrt_reg_t;
endpackage

/* File: hw/lrt_regs.sv */
// byte register bank and play/crossing timers of the resonance tracking engine
`include "lrt_defs.svh"
module lrt_regs #(
  parameter int PLAY_UNIT_CYC = `LRT_PLAY_UNIT_CYC,
  parameter int NZC_UNIT_CYC = `LRT_NZC_UNIT_CYC
) (
  input wire logic I_CORE_CLK,
  input wire logic I_ARST_N,
  input wire logic i_WR_EN,
  input wire logic i_RD_EN,
  input wire lrt_pkg::lrt_byte_t i_ADDR,
  input wire lrt_pkg::lrt_byte_t i_WDATA,
  input wire logic i_PERIOD_WE,
  input wire lrt_pkg::lrt_period_t i_PERIOD_VAL,
  input wire logic i_PLAY_ACTIVE,
  input wire logic i_ZERO_CROSS,
  output lrt_pkg::lrt_byte_t o_RDATA,
  output logic o_RD_VALID,
  output logic o_CLOSED_LOOP,
  output logic o_TIMED_PLAY,
  output lrt_pkg::lrt_period_t o_PERIOD,
  output lrt_pkg::lrt_byte_t o_POS_LIMIT,
  output lrt_pkg::lrt_byte_t o_NEG_LIMIT,
  output logic [3:0] o_BRAKE_PULSES,
  output lrt_pkg::lrt_byte_t o_PLAY_DURATION,
  output lrt_pkg::lrt_byte_t o_NZC_LIMIT,
  output lrt_pkg::lrt_byte_t o_NORMAL_AMP,
  output lrt_pkg::lrt_byte_t o_OVERDRIVE_AMP,
  output logic [3:0] o_FIRST_PLAYS,
  output lrt_pkg::lrt_byte_t o_DETECT_REPEATS,
  output lrt_pkg::lrt_byte_t o_LATER_PLAYS,
  output logic o_PLAY_EXPIRED,
  output logic o_NZC_TIMEOUT
);
  import lrt_pkg::*;

  localparam int NREG = int'(LRT_R_COUNT);
  localparam int PW = $clog2(PLAY_UNIT_CYC + 1);
  localparam int NW = $clog2(NZC_UNIT_CYC + 1);
  localparam logic [PW-1:0] PLAY_LAST = PW'(PLAY_UNIT_CYC - 1);
  localparam logic [NW-1:0] NZC_LAST = NW'(NZC_UNIT_CYC - 1);

  lrt_byte_t regs [NREG];
  lrt_byte_t next_regs [NREG];
  lrt_byte_t rdata;
  lrt_byte_t next_rdata;
  logic rd_valid;
  logic next_rd_valid;
  logic hit;
  int unsigned sel;

  // address decode; unmapped bytes read zero and ignore writes
  always_comb begin
    hit = 1'b1;
    sel = 0;
    unique case (i_ADDR)
      `LRT_ADDR_CTRL: sel = int'(LRT_R_CTRL);
      `LRT_ADDR_PER_HI: sel = int'(LRT_R_PER_HI);
      `LRT_ADDR_PER_LO: sel = int'(LRT_R_PER_LO);
      `LRT_ADDR_POS_LIM: sel = int'(LRT_R_POS_LIM);
      `LRT_ADDR_NEG_LIM: sel = int'(LRT_R_NEG_LIM);
      `LRT_ADDR_BRAKE: sel = int'(LRT_R_BRAKE);
      `LRT_ADDR_PLAY_DUR: sel = int'(LRT_R_PLAY_DUR);
      `LRT_ADDR_NZC: sel = int'(LRT_R_NZC);
      `LRT_ADDR_NORM_AMP: sel = int'(LRT_R_NORM_AMP);
      `LRT_ADDR_OVD_AMP: sel = int'(LRT_R_OVD_AMP);
      `LRT_ADDR_FIRST: sel = int'(LRT_R_FIRST);
      `LRT_ADDR_REPEAT: sel = int'(LRT_R_REPEAT);
      `LRT_ADDR_LATER: sel = int'(LRT_R_LATER);
      default: hit = 1'b0;
    endcase
  end

  always_comb begin
    next_regs = regs;
    if (i_WR_EN && hit) begin
      next_regs[sel] = i_WDATA;
    end
    // engine result wins
    // engine result beats a host write in the same cycle so a fresh measurement is never lost
    if (i_PERIOD_WE) begin
      next_regs[LRT_R_PER_HI] = i_PERIOD_VAL[15:8];
      next_regs[LRT_R_PER_LO] = i_PERIOD_VAL[7:0];
    end
    next_rd_valid = i_RD_EN;
    next_rdata = rdata;
    if (i_RD_EN) begin
      next_rdata = hit ? regs[sel] : 8'h00;
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      regs[LRT_R_CTRL] <= `LRT_RST_CTRL;
      regs[LRT_R_PER_HI] <= `LRT_RST_PER_HI;
      regs[LRT_R_PER_LO] <= `LRT_RST_PER_LO;
      regs[LRT_R_POS_LIM] <= `LRT_RST_POS_LIM;
      regs[LRT_R_NEG_LIM] <= `LRT_RST_NEG_LIM;
      regs[LRT_R_BRAKE] <= `LRT_RST_BRAKE;
      regs[LRT_R_PLAY_DUR] <= `LRT_RST_PLAY_DUR;
      regs[LRT_R_NZC] <= `LRT_RST_NZC;
      regs[LRT_R_NORM_AMP] <= `LRT_RST_NORM_AMP;
      regs[LRT_R_OVD_AMP] <= `LRT_RST_OVD_AMP;
      regs[LRT_R_FIRST] <= `LRT_RST_FIRST;
      regs[LRT_R_REPEAT] <= `LRT_RST_REPEAT;
      regs[LRT_R_LATER] <= `LRT_RST_LATER;
      rdata <= 8'h00;
      rd_valid <= 1'b0;
    end else begin
      regs <= next_regs;
      rdata <= next_rdata;
      rd_valid <= next_rd_valid;
    end
  end

  assign o_RDATA = rdata;
  assign o_RD_VALID = rd_valid;
  assign o_CLOSED_LOOP = regs[LRT_R_CTRL][`LRT_CTRL_CLOSED_BIT];
  assign o_TIMED_PLAY = regs[LRT_R_CTRL][`LRT_CTRL_TIMED_BIT];
  assign o_PERIOD = {regs[LRT_R_PER_HI], regs[LRT_R_PER_LO]};
  assign o_POS_LIMIT = regs[LRT_R_POS_LIM];
  assign o_NEG_LIMIT = regs[LRT_R_NEG_LIM];
  assign o_BRAKE_PULSES = regs[LRT_R_BRAKE][`LRT_BRAKE_MSB:`LRT_BRAKE_LSB];
  assign o_PLAY_DURATION = regs[LRT_R_PLAY_DUR];
  assign o_NZC_LIMIT = regs[LRT_R_NZC];
  assign o_NORMAL_AMP = regs[LRT_R_NORM_AMP];
  assign o_OVERDRIVE_AMP = regs[LRT_R_OVD_AMP];
  assign o_FIRST_PLAYS = regs[LRT_R_FIRST][`LRT_FIRST_MSB:`LRT_FIRST_LSB];
  assign o_DETECT_REPEATS = regs[LRT_R_REPEAT];
  assign o_LATER_PLAYS = regs[LRT_R_LATER];

  // play timer: prescaler to whole units, then unit count against the setting
  logic [PW-1:0] play_pre;
  logic [PW-1:0] next_play_pre;
  logic [8:0] play_units;
  logic [8:0] next_play_units;
  logic play_exp;
  logic next_play_exp;
  logic play_timed;
  // limit applies in tracking or open-loop play
  assign play_timed = i_PLAY_ACTIVE && regs[LRT_R_CTRL][`LRT_CTRL_TIMED_BIT];

  always_comb begin
    next_play_pre = play_pre;
    next_play_units = play_units;
    next_play_exp = play_exp;
    if (!play_timed) begin
      next_play_pre = '0;
      next_play_units = '0;
      next_play_exp = 1'b0;
    end else if (!play_exp) begin
      if (play_pre == PLAY_LAST) begin
        next_play_pre = '0;
        next_play_units = play_units + 9'h001;
      end else begin
        next_play_pre = play_pre + PW'(1);
      end
      if (play_units >= {1'b0, regs[LRT_R_PLAY_DUR]}) begin
        next_play_exp = 1'b1;
      end
    end
  end

  // missing crossing timer, restarted by every detected crossing
  logic [NW-1:0] nzc_pre;
  logic [NW-1:0] next_nzc_pre;
  logic [8:0] nzc_units;
  logic [8:0] next_nzc_units;
  logic nzc_to;
  logic next_nzc_to;

  always_comb begin
    next_nzc_pre = nzc_pre;
    next_nzc_units = nzc_units;
    next_nzc_to = nzc_to;
    if (!i_PLAY_ACTIVE || i_ZERO_CROSS) begin
      next_nzc_pre = '0;
      next_nzc_units = '0;
      next_nzc_to = 1'b0;
    end else if (!nzc_to) begin
      if (nzc_pre == NZC_LAST) begin
        next_nzc_pre = '0;
        next_nzc_units = nzc_units + 9'h001;
      end else begin
        next_nzc_pre = nzc_pre + NW'(1);
      end
      // flag on the cycle past the setting time
      // units reach the setting once that time is used up, so the flag lands one cycle after
      if (nzc_units >= {1'b0, regs[LRT_R_NZC]}) begin
        next_nzc_to = 1'b1;
      end
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      play_pre <= '0;
      play_units <= 9'h000;
      play_exp <= 1'b0;
      nzc_pre <= '0;
      nzc_units <= 9'h000;
      nzc_to <= 1'b0;
    end else begin
      play_pre <= next_play_pre;
      play_units <= next_play_units;
      play_exp <= next_play_exp;
      nzc_pre <= next_nzc_pre;
      nzc_units <= next_nzc_units;
      nzc_to <= next_nzc_to;
    end
  end

  assign o_PLAY_EXPIRED = play_exp;
  assign o_NZC_TIMEOUT = nzc_to;

  period_update_a: assert property (
    @(posedge I_CORE_CLK) disable iff (!I_ARST_N)
    i_PERIOD_WE |=> o_PERIOD == $past(i_PERIOD_VAL))
    else $error("tracked period not captured");
  pos_limit_wr_a: assert property (
    @(posedge I_CORE_CLK) disable iff (!I_ARST_N)
    i_WR_EN && i_ADDR == `LRT_ADDR_POS_LIM |=> o_POS_LIMIT == $past(i_WDATA))
    else $error("positive limit write lost");
  neg_limit_wr_a: assert property (
    @(posedge I_CORE_CLK) disable iff (!I_ARST_N)
    i_WR_EN && i_ADDR == `LRT_ADDR_NEG_LIM |=> o_NEG_LIMIT == $past(i_WDATA))
    else $error("negative limit write lost");
  brake_nibble_a: assert property (
    @(posedge I_CORE_CLK) disable iff (!I_ARST_N)
    i_WR_EN && i_ADDR == `LRT_ADDR_BRAKE |=> o_BRAKE_PULSES == $past(i_WDATA[3:0]))
    else $error("brake count not from low nibble");
  play_expiry_a: assert property (
    @(posedge I_CORE_CLK) disable iff (!I_ARST_N)
    $rose(o_PLAY_EXPIRED) |-> $past(play_units) >= {1'b0, o_PLAY_DURATION} && o_TIMED_PLAY)
    else $error("play expired early");
  nzc_expiry_a: assert property (
    @(posedge I_CORE_CLK) disable iff (!I_ARST_N)
    $rose(o_NZC_TIMEOUT) |-> $past(nzc_units) >= {1'b0, o_NZC_LIMIT} && !$past(i_ZERO_CROSS))
    else $error("crossing timeout early");
  amp_levels_a: assert property (
    @(posedge I_CORE_CLK) disable iff (!I_ARST_N)
    i_WR_EN && i_ADDR == `LRT_ADDR_NORM_AMP ##1 !i_WR_EN |=> o_NORMAL_AMP == $past(i_WDATA, 2))
    else $error("normal amplitude not held");
  overdrive_amp_a: assert property (
    @(posedge I_CORE_CLK) disable iff (!I_ARST_N)
    i_WR_EN && i_ADDR == `LRT_ADDR_OVD_AMP |=> o_OVERDRIVE_AMP == $past(i_WDATA))
    else $error("overdrive amplitude write lost");
  first_plays_a: assert property (
    @(posedge I_CORE_CLK) disable iff (!I_ARST_N)
    i_WR_EN && i_ADDR == `LRT_ADDR_FIRST |=> o_FIRST_PLAYS == $past(i_WDATA[7:4]))
    else $error("first plays not from high nibble");
  repeat_cnt_a: assert property (
    @(posedge I_CORE_CLK) disable iff (!I_ARST_N)
    i_WR_EN && i_ADDR == `LRT_ADDR_REPEAT |=> o_DETECT_REPEATS == $past(i_WDATA))
    else $error("repeat count write lost");
  later_plays_a: assert property (
    @(posedge I_CORE_CLK) disable iff (!I_ARST_N)
    i_WR_EN && i_ADDR == `LRT_ADDR_LATER |=> o_LATER_PLAYS == $past(i_WDATA))
    else $error("later plays write lost");
  period_hi_wr_a: assert property (
    @(posedge I_CORE_CLK) disable iff (!I_ARST_N)
    i_WR_EN && i_ADDR == `LRT_ADDR_PER_HI && !i_PERIOD_WE
    |=> o_PERIOD[15:8] == $past(i_WDATA))
    else $error("period high byte write lost");
  loop_mode_a: assert property (
    @(posedge I_CORE_CLK) disable iff (!I_ARST_N)
    i_WR_EN && i_ADDR == `LRT_ADDR_CTRL |=> o_CLOSED_LOOP == $past(i_WDATA[3]))
    else $error("loop mode bit wrong");
  readback_a: assert property (
    @(posedge I_CORE_CLK) disable iff (!I_ARST_N)
    i_WR_EN && hit && !i_PERIOD_WE ##1 i_RD_EN && $stable(i_ADDR)
    |=> o_RD_VALID && o_RDATA == $past(i_WDATA, 2))
    else $error("readback differs from write");
  unmapped_rd_a: assert property (
    @(posedge I_CORE_CLK) disable iff (!I_ARST_N)
    i_RD_EN && !hit |=> o_RD_VALID && o_RDATA == 8'h00)
    else $error("unmapped read not zero");
endmodule

/* File: dv/lrt_host.sv */
// host model that drives byte reads and writes into the register bank
module lrt_host import lrt_pkg::*; (
  input wire logic i_clk,
  input wire lrt_pkg::lrt_byte_t i_rdata,
  input wire logic i_rd_valid,
  output logic o_wr_en,
  output logic o_rd_en,
  output lrt_pkg::lrt_byte_t o_addr,
  output lrt_pkg::lrt_byte_t o_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_wr_en = 1'b0;
    o_rd_en = 1'b0;
    o_addr = 8'h00;
    o_wdata = 8'h00;
  end
  // released lines flip so a stale value never looks valid
  task automatic wr(input lrt_byte_t a, input lrt_byte_t d);
    @(posedge i_clk);
    o_wr_en <= 1'b1;
    o_addr <= a;
    o_wdata <= d;
    @(posedge i_clk);
    o_wr_en <= 1'b0;
    o_addr <= ~a;
    o_wdata <= ~d;
  endtask
  task automatic rd(input lrt_byte_t a, output lrt_byte_t d, output logic v);
    @(posedge i_clk);
    o_rd_en <= 1'b1;
    o_addr <= a;
    @(posedge i_clk);
    o_rd_en <= 1'b0;
    o_addr <= ~a;
    // valid stands only in the cycle right after the strobe
    @(negedge i_clk);
    v = i_rd_valid;
    d = i_rdata;
  endtask
  // write, then read the same byte at the very next edge
  task automatic wr_rd(input lrt_byte_t a, input lrt_byte_t d, output lrt_byte_t q,
    output logic v);
    @(posedge i_clk);
    o_wr_en <= 1'b1;
    o_addr <= a;
    o_wdata <= d;
    @(posedge i_clk);
    o_wr_en <= 1'b0;
    o_rd_en <= 1'b1;
    o_wdata <= ~d;
    @(posedge i_clk);
    o_rd_en <= 1'b0;
    o_addr <= ~a;
    @(negedge i_clk);
    v = i_rd_valid;
    q = i_rdata;
  endtask
endmodule

/* File: dv/tb.sv */
// self-checking bench for the tracking parameter bank
`include "lrt_defs.svh"
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin fails++; \
  $display("BAD %s exp %0h got %0h", nm, e, g); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import lrt_pkg::*;
  logic clk, arst_n, wr_en, rd_en, per_we, play, zc, rdv, cl, tp, pexp, nto;
  lrt_byte_t addr, wdata, rdata, pos, neg, dur, nzl, namp, oamp, rep, later;
  lrt_period_t per_val, per;
  logic [3:0] brk, first;
  lrt_byte_t rq;
  logic rv;
  int fails = 0;
  int num_checks = 0;
  int n;
  lrt_byte_t adr [13] = '{`LRT_ADDR_CTRL, `LRT_ADDR_PER_HI, `LRT_ADDR_PER_LO,
    `LRT_ADDR_POS_LIM, `LRT_ADDR_NEG_LIM, `LRT_ADDR_BRAKE, `LRT_ADDR_PLAY_DUR, `LRT_ADDR_NZC,
    `LRT_ADDR_NORM_AMP, `LRT_ADDR_OVD_AMP, `LRT_ADDR_FIRST, `LRT_ADDR_REPEAT, `LRT_ADDR_LATER};
  lrt_byte_t rst [13] = '{`LRT_RST_CTRL, `LRT_RST_PER_HI, `LRT_RST_PER_LO,
    `LRT_RST_POS_LIM, `LRT_RST_NEG_LIM, `LRT_RST_BRAKE, `LRT_RST_PLAY_DUR, `LRT_RST_NZC,
    `LRT_RST_NORM_AMP, `LRT_RST_OVD_AMP, `LRT_RST_FIRST, `LRT_RST_REPEAT, `LRT_RST_LATER};
  // short timer units keep the run small
  lrt_regs #(.PLAY_UNIT_CYC(4), .NZC_UNIT_CYC(2)) u_lrt_regs (.I_CORE_CLK(clk),
    .I_ARST_N(arst_n), .i_WR_EN(wr_en), .i_RD_EN(rd_en), .i_ADDR(addr), .i_WDATA(wdata),
    .i_PERIOD_WE(per_we), .i_PERIOD_VAL(per_val), .i_PLAY_ACTIVE(play), .i_ZERO_CROSS(zc),
    .o_RDATA(rdata), .o_RD_VALID(rdv), .o_CLOSED_LOOP(cl), .o_TIMED_PLAY(tp), .o_PERIOD(per),
    .o_POS_LIMIT(pos), .o_NEG_LIMIT(neg), .o_BRAKE_PULSES(brk), .o_PLAY_DURATION(dur),
    .o_NZC_LIMIT(nzl), .o_NORMAL_AMP(namp), .o_OVERDRIVE_AMP(oamp), .o_FIRST_PLAYS(first),
    .o_DETECT_REPEATS(rep), .o_LATER_PLAYS(later), .o_PLAY_EXPIRED(pexp),
    .o_NZC_TIMEOUT(nto));
  lrt_host u_lrt_host (.i_clk(clk), .i_rdata(rdata), .i_rd_valid(rdv), .o_wr_en(wr_en),
    .o_rd_en(rd_en), .o_addr(addr), .o_wdata(wdata));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic rdchk(input lrt_byte_t a, input lrt_byte_t e);
    lrt_byte_t d;
    logic v;
    u_lrt_host.rd(a, d, v);
    `CHK("rd_valid", 1'b1, v)
    `CHK("rd_data", e, d)
  endtask
  // counts edges until a timer flag rises, capped so a dead timer cannot hang
  // flags are looked at on the falling edge, where they have settled
  task automatic wait_flag(input bit nzc_sel);
    n = 0;
    @(negedge clk);
    while ((nzc_sel ? nto : pexp) !== 1'b1 && n < 60) begin
      @(negedge clk);
      n++;
    end
  endtask
  initial begin
    #100us;
    fails++;
    $display("watchdog expired");
    end_of_test();
  end
  initial begin
    arst_n = 1'b0;
    per_we = 1'b0;
    per_val = 16'h0000;
    play = 1'b0;
    zc = 1'b0;
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    for (int i = 0; i < 13; i++) rdchk(adr[i], rst[i]);
    `CHK("brake", 4'h3, brk)
    `CHK("first", 4'h5, first)
    `CHK("closed", 1'b1, cl)
    `CHK("repeat", 8'h05, rep)
    $display("test reset values done");
    for (int i = 0; i < 13; i++) u_lrt_host.wr(adr[i], adr[i] ^ 8'hA5);
    u_lrt_host.wr(8'h50, 8'h3C);
    for (int i = 0; i < 13; i++) rdchk(adr[i], adr[i] ^ 8'hA5);
    rdchk(8'h50, 8'h00);
    `CHK("period", 16'hCFCE, per)
    `CHK("pos", 8'hD7, pos)
    `CHK("neg", 8'hD6, neg)
    `CHK("brake", 4'hD, brk)
    `CHK("dur", 8'hDC, dur)
    `CHK("nzc", 8'hDF, nzl)
    `CHK("norm", 8'hDE, namp)
    `CHK("ovd", 8'hD9, oamp)
    `CHK("first", 4'hD, first)
    `CHK("repeat", 8'hDB, rep)
    `CHK("later", 8'hDA, later)
    u_lrt_host.wr_rd(`LRT_ADDR_POS_LIM, 8'h5A, rq, rv);
    `CHK("wr_rd_valid", 1'b1, rv)
    `CHK("wr_rd_data", 8'h5A, rq)
    $display("test write readback done");
    fork
      u_lrt_host.wr(`LRT_ADDR_PER_LO, 8'h77);
      begin
        @(posedge clk);
        per_we <= 1'b1;
        per_val <= 16'h1234;
        @(posedge clk);
        per_we <= 1'b0;
      end
    join
    @(negedge clk);
    `CHK("period", 16'h1234, per)
    rdchk(`LRT_ADDR_PER_HI, 8'h12);
    rdchk(`LRT_ADDR_PER_LO, 8'h34);
    u_lrt_host.wr(`LRT_ADDR_CTRL, 8'h91);
    @(negedge clk);
    `CHK("closed", 1'b0, cl)
    `CHK("timed", 1'b1, tp)
    $display("test period and control done");
    u_lrt_host.wr(`LRT_ADDR_PLAY_DUR, 8'h03);
    u_lrt_host.wr(`LRT_ADDR_NZC, 8'h02);
    @(posedge clk);
    play <= 1'b1;
    zc <= 1'b0;
    wait_flag(1'b1);
    // timeout lands on the edge after 2*2 cycles without a crossing: edge 5 of play
    `CHK("nzc_cycles", 1'b1, n == 5)
    @(posedge clk);
    zc <= 1'b1;
    @(posedge clk);
    zc <= 1'b0;
    @(negedge clk);
    `CHK("nzc_clear", 1'b0, nto)
    wait_flag(1'b0);
    // expiry on edge 3*4+1 = 13 of play; this wait counts from the fall after edge 8
    `CHK("play_cycles", 1'b1, n == 5)
    @(posedge clk);
    play <= 1'b0;
    @(negedge clk);
    `CHK("play_hold", 1'b1, pexp)
    @(negedge clk);
    `CHK("play_clear", 1'b0, pexp)
    u_lrt_host.wr(`LRT_ADDR_CTRL, 8'h89);
    play <= 1'b1;
    repeat (30) @(negedge clk);
    `CHK("untimed", 1'b0, pexp)
    `CHK("nzc_untimed", 1'b1, nto)
    @(posedge clk);
    play <= 1'b0;
    $display("test timers done");
    end_of_test();
  end
endmodule
